// ===== sensor_output_map.vh
// Constants of the sensor output event controller: register map, fields, resets, timing
`ifndef SENSOR_OUTPUT_MAP_VH
`define SENSOR_OUTPUT_MAP_VH

// Clock rate and documented times
`define CLOCK_HZ            100000000
`define MS_PER_S            1000
`define HOLD_TIME_MS        1000
`define ZOOM_RATE_HZ        60

// Register byte offsets on the Avalon-MM slave
`define REG_CTRL            8'h00
`define REG_DEACT_MS        8'h04
`define REG_RAMP_MS         8'h08
`define REG_SAMPLE_MS       8'h0C
`define REG_DUTY_DEFAULT    8'h10
`define REG_STATUS          8'h14

// Control register fields
`define CTRL_ACTIVE_LOW     0
`define CTRL_OPEN_DRAIN     1
`define CTRL_METAL_MODE     2
`define CTRL_COIL_TOUCH_EN  3
`define CTRL_WIDTH          4

// Status register fields
`define STAT_STATE_LO       0
`define STAT_STATE_HI       1
`define STAT_ZOOM           2
`define STAT_DIM_UP         3
`define STAT_EVENT          4
`define STAT_OUT_LEVEL      5
`define STAT_DUTY_LO        8
`define STAT_DUTY_HI        15

// Reset values, standing in for the stored configuration
`define RST_CTRL            4'h0
`define RST_DEACT_MS        16'h2710
`define RST_RAMP_MS         16'h000A
`define RST_SAMPLE_MS       16'h0064
`define RST_DUTY_DEFAULT    8'hFF

// Output states
`define ST_INACTIVE         2'h0
`define ST_PWM              2'h1
`define ST_ACTIVE           2'h2

// Synchronised input bit positions
`define IN_MOTION           0
`define IN_IR_BLOCKED       1
`define IN_PROX             2
`define IN_TOUCH            3
`define IN_METAL            4
`define IN_COIL_TOUCH       5
`define IN_COUNT            6

`endif

// ===== input_filter.v
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module input_filter #(
  parameter WIDTH = 1
) (
  input  wire             clock,
  input  wire             rst,
  input  wire [WIDTH-1:0] pin,
  output wire [WIDTH-1:0] level
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync2_q;
  reg [WIDTH-1:0] sync3_q;
  reg [WIDTH-1:0] level_q;
  integer         i;

  ////////////////////////////////////////////////////////////////////////////
  // Shift chain; a change counts once stages two and three agree
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_q  <= {WIDTH{1'b0}};
      sync2_q <= {WIDTH{1'b0}};
      sync3_q <= {WIDTH{1'b0}};
      level_q <= {WIDTH{1'b0}};
    end else begin
      meta_q  <= pin;
      sync2_q <= meta_q;
      sync3_q <= sync2_q;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (sync2_q[i] == sync3_q[i]) begin
          level_q[i] <= sync3_q[i];
        end
      end
    end
  end

  assign level = level_q;

endmodule // input_filter

// ===== sensor_output_event_controller.v
// Output state machine, PWM dimming, sampler rate and Avalon-MM registers
`timescale 1ns/1ps
`include "sensor_output_map.vh"
module sensor_output_event_controller #(
  parameter integer MS_CYCLES   = `CLOCK_HZ / `MS_PER_S,
  parameter integer HOLD_CYCLES = (`CLOCK_HZ / `MS_PER_S) * `HOLD_TIME_MS,
  parameter integer ZOOM_CYCLES = `CLOCK_HZ / `ZOOM_RATE_HZ,
  parameter integer DUTY_WIDTH  = 8
) (
  input  wire        clock,
  input  wire        rst,
  input  wire [7:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  output reg  [31:0] readdata,
  output wire        waitrequest,
  input  wire        infrared_motion_sensor,
  input  wire        ir_blocked,
  input  wire        prox_detect,
  input  wire        touch_detect,
  input  wire        metal_detect,
  input  wire        coil_touch,
  output wire        out_level,
  output wire        out_oe,
  output wire        event_out,
  output wire        sample_strobe,
  output wire        zoom_mode
);

  localparam [DUTY_WIDTH-1:0] DUTY_MAX = {DUTY_WIDTH{1'b1}};
  localparam [DUTY_WIDTH-1:0] DUTY_MIN = {DUTY_WIDTH{1'b0}};

  // Synchronised pins
  wire [`IN_COUNT-1:0] pins;
  wire [`IN_COUNT-1:0] lvl;
  reg  [`IN_COUNT-1:0] lvl_prev_q;
  wire                 motion_rise;
  wire                 prox_rise;
  wire                 touch_rise;

  // Configuration registers
  reg [`CTRL_WIDTH-1:0]  ctrl_q;
  reg [15:0]             deact_ms_q;
  reg [15:0]             ramp_ms_q;
  reg [15:0]             sample_ms_q;
  reg [DUTY_WIDTH-1:0]   duty_default_q;

  // Bus handshake
  reg                    ack_q;
  wire                   access;
  wire                   wr_take;

  // Output control state
  reg [1:0]              state_q;
  reg [1:0]              state_d;
  reg [DUTY_WIDTH-1:0]   duty_q;
  reg                    dim_up_q;
  reg                    holding_q;
  reg [31:0]             hold_cnt_q;
  reg                    dimming_q;
  reg [31:0]             ms_cnt_q;
  wire                   ms_tick;
  reg [15:0]             deact_cnt_q;
  reg [15:0]             ramp_cnt_q;
  reg                    zoom_q;
  reg [31:0]             sample_cnt_q;
  wire [31:0]            sample_limit;
  reg                    sample_q;
  reg [DUTY_WIDTH-1:0]   pwm_cnt_q;
  reg                    out_on_q;
  reg                    event_q;
  wire                   metal_mode;
  wire                   metal_block;
  wire                   on_level;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  assign pins[`IN_MOTION]     = infrared_motion_sensor;
  assign pins[`IN_IR_BLOCKED] = ir_blocked;
  assign pins[`IN_PROX]       = prox_detect;
  assign pins[`IN_TOUCH]      = touch_detect;
  assign pins[`IN_METAL]      = metal_detect;
  assign pins[`IN_COIL_TOUCH] = coil_touch;

  input_filter #(
    .WIDTH (`IN_COUNT)
  ) u_input_filter (
    .clock (clock),
    .rst   (rst),
    .pin   (pins),
    .level (lvl)
  );

  // Edge detection on filtered levels
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      lvl_prev_q <= {`IN_COUNT{1'b0}};
    end else begin
      lvl_prev_q <= lvl;
    end
  end

  assign motion_rise = lvl[`IN_MOTION] & ~lvl_prev_q[`IN_MOTION];
  assign prox_rise   = lvl[`IN_PROX] & ~lvl_prev_q[`IN_PROX];
  assign touch_rise  = lvl[`IN_TOUCH] & ~lvl_prev_q[`IN_TOUCH];

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM handshake: one wait cycle, answer on the second edge
  assign access      = read | write;
  assign waitrequest = access & ~ack_q;
  assign wr_take     = write & ack_q;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= access & ~ack_q;
    end
  end

  // Configuration writes; reset values act as the stored configuration
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ctrl_q         <= `RST_CTRL;
      deact_ms_q     <= `RST_DEACT_MS;
      ramp_ms_q      <= `RST_RAMP_MS;
      sample_ms_q    <= `RST_SAMPLE_MS;
      duty_default_q <= `RST_DUTY_DEFAULT;
    end else if (wr_take) begin
      case (address)
        `REG_CTRL:         ctrl_q         <= writedata[`CTRL_WIDTH-1:0];
        `REG_DEACT_MS:     deact_ms_q     <= writedata[15:0];
        `REG_RAMP_MS:      ramp_ms_q      <= writedata[15:0];
        `REG_SAMPLE_MS:    sample_ms_q    <= writedata[15:0];
        `REG_DUTY_DEFAULT: duty_default_q <= writedata[DUTY_WIDTH-1:0];
        default:           ctrl_q         <= ctrl_q;
      endcase
    end
  end

  // Read data captured in the wait cycle, stands at the answer edge
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      readdata <= 32'h00000000;
    end else if (read & ~ack_q) begin
      readdata <= 32'h00000000;
      case (address)
        `REG_CTRL:         readdata[`CTRL_WIDTH-1:0] <= ctrl_q;
        `REG_DEACT_MS:     readdata[15:0]            <= deact_ms_q;
        `REG_RAMP_MS:      readdata[15:0]            <= ramp_ms_q;
        `REG_SAMPLE_MS:    readdata[15:0]            <= sample_ms_q;
        `REG_DUTY_DEFAULT: readdata[DUTY_WIDTH-1:0]  <= duty_default_q;
        `REG_STATUS: begin
          readdata[`STAT_STATE_HI:`STAT_STATE_LO] <= state_q;
          readdata[`STAT_ZOOM]                    <= zoom_q;
          readdata[`STAT_DIM_UP]                  <= dim_up_q;
          readdata[`STAT_EVENT]                   <= event_q;
          readdata[`STAT_OUT_LEVEL]               <= out_on_q;
          readdata[`STAT_DUTY_HI:`STAT_DUTY_LO]   <= duty_q;
        end
        default:           readdata <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Millisecond time base for deactivation and ramp timers
  assign ms_tick = (ms_cnt_q == MS_CYCLES - 1);

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      ms_cnt_q <= 32'h00000000;
    end else if (ms_tick) begin
      ms_cnt_q <= 32'h00000000;
    end else begin
      ms_cnt_q <= ms_cnt_q + 32'h00000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output state decision
  assign metal_mode  = ctrl_q[`CTRL_METAL_MODE];
  assign metal_block = ctrl_q[`CTRL_COIL_TOUCH_EN] & lvl[`IN_COIL_TOUCH];

  always @* begin
    state_d = state_q;
    if (metal_mode) begin
      if (!metal_block) begin
        state_d = lvl[`IN_METAL] ? `ST_INACTIVE : `ST_ACTIVE;
      end
    end else begin
      case (state_q)
        `ST_INACTIVE: begin
          if (touch_rise) begin
            state_d = `ST_ACTIVE;
          end else if (motion_rise) begin
            state_d = `ST_PWM;
          end
        end
        `ST_PWM: begin
          if (touch_rise) begin
            state_d = `ST_ACTIVE;
          end else if (!motion_rise && ms_tick && deact_cnt_q == 16'h0001) begin
            state_d = `ST_INACTIVE;
          end
        end
        `ST_ACTIVE: begin
          if (touch_rise) begin
            state_d = `ST_INACTIVE;
          end
        end
        default: state_d = `ST_INACTIVE;
      endcase
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= `ST_INACTIVE;
    end else begin
      state_q <= state_d;
    end
  end

  // Deactivation timer in milliseconds, reloaded on movement in PWM mode
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      deact_cnt_q <= 16'h0000;
    end else if (state_d == `ST_PWM && (state_q != `ST_PWM || motion_rise)) begin
      deact_cnt_q <= deact_ms_q;
    end else if (state_q == `ST_PWM && ms_tick && deact_cnt_q != 16'h0000) begin
      deact_cnt_q <= deact_cnt_q - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Touch hold timer and duty ramp
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      holding_q  <= 1'b0;
      dimming_q  <= 1'b0;
      hold_cnt_q <= 32'h00000000;
    end else if (!metal_mode && state_q == `ST_INACTIVE && state_d == `ST_ACTIVE) begin
      holding_q  <= 1'b1;
      dimming_q  <= 1'b0;
      hold_cnt_q <= 32'h00000000;
    end else if (!lvl[`IN_TOUCH] || state_q != `ST_ACTIVE) begin
      holding_q  <= 1'b0;
      dimming_q  <= 1'b0;
    end else if (holding_q && !dimming_q) begin
      if (hold_cnt_q == HOLD_CYCLES - 1) begin
        dimming_q <= 1'b1;
      end else begin
        hold_cnt_q <= hold_cnt_q + 32'h00000001;
      end
    end
  end

  // Ramp: down first, turn up at zero, turn down at full, hold on release
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      duty_q     <= `RST_DUTY_DEFAULT;
      dim_up_q   <= 1'b0;
      ramp_cnt_q <= 16'h0000;
    end else if (!dimming_q) begin
      dim_up_q   <= 1'b0;
      ramp_cnt_q <= 16'h0000;
    end else if (ms_tick) begin
      if (ramp_cnt_q + 16'h0001 >= ramp_ms_q) begin
        ramp_cnt_q <= 16'h0000;
        if (dim_up_q) begin
          if (duty_q == DUTY_MAX) begin
            dim_up_q <= 1'b0;
            duty_q   <= duty_q - 1'b1;
          end else begin
            duty_q   <= duty_q + 1'b1;
          end
        end else if (duty_q == DUTY_MIN) begin
          dim_up_q <= 1'b1;
          duty_q   <= duty_q + 1'b1;
        end else begin
          duty_q   <= duty_q - 1'b1;
        end
      end else begin
        ramp_cnt_q <= ramp_cnt_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Zoom mode: set by prox, left when prox and touch are both gone
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      zoom_q <= 1'b0;
    end else if (prox_rise) begin
      zoom_q <= 1'b1;
    end else if (!lvl[`IN_PROX] && !lvl[`IN_TOUCH]) begin
      zoom_q <= 1'b0;
    end
  end

  // Electrode sample strobe at zoom or normal rate
  // A zero period gives a strobe every cycle instead of wrapping the limit
  assign sample_limit = zoom_q ? ZOOM_CYCLES - 1
                      : (sample_ms_q == 16'h0000) ? 32'h00000000
                      : sample_ms_q * MS_CYCLES - 1;

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      sample_cnt_q <= 32'h00000000;
      sample_q     <= 1'b0;
    end else if (sample_cnt_q >= sample_limit) begin
      sample_cnt_q <= 32'h00000000;
      sample_q     <= 1'b1;
    end else begin
      sample_cnt_q <= sample_cnt_q + 32'h00000001;
      sample_q     <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // PWM generator and pin drive
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      pwm_cnt_q <= DUTY_MIN;
      out_on_q  <= 1'b0;
    end else begin
      pwm_cnt_q <= pwm_cnt_q + 1'b1;
      case (state_q)
        `ST_PWM:    out_on_q <= (pwm_cnt_q < duty_default_q);
        `ST_ACTIVE: out_on_q <= (duty_q == DUTY_MAX) | (pwm_cnt_q < duty_q);
        default:    out_on_q <= 1'b0;
      endcase
    end
  end

  // Polarity and drive style
  assign on_level  = out_on_q ^ ctrl_q[`CTRL_ACTIVE_LOW];
  assign out_level = on_level;
  assign out_oe    = ctrl_q[`CTRL_OPEN_DRAIN] ? ~on_level : 1'b1;

  // Event pin on movement or blocked infrared sensor
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      event_q <= 1'b0;
    end else begin
      event_q <= lvl[`IN_MOTION] | lvl[`IN_IR_BLOCKED];
    end
  end

  assign event_out     = event_q;
  assign sample_strobe = sample_q;
  assign zoom_mode     = zoom_q;

endmodule // sensor_output_event_controller

// ===== sensor_output_event_controller_properties.sv
// Port-level checks of the sensor output event controller
`timescale 1ns/1ps
module sensor_output_event_controller_properties #(
  parameter integer ZOOM_CYCLES = 20
) (
  input wire        clock,
  input wire        rst,
  input wire [7:0]  address,
  input wire        read,
  input wire        write,
  input wire [31:0] writedata,
  input wire [31:0] readdata,
  input wire        waitrequest,
  input wire        infrared_motion_sensor,
  input wire        ir_blocked,
  input wire        prox_detect,
  input wire        touch_detect,
  input wire        metal_detect,
  input wire        coil_touch,
  input wire        out_level,
  input wire        out_oe,
  input wire        event_out,
  input wire        sample_strobe,
  input wire        zoom_mode
);
  reg [7:0]  quiet_ev_q;
  reg [7:0]  quiet_zm_q;
  reg [31:0] gap_q;
  reg [31:0] zage_q;

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  ////////////////////////////////////////////////////////////////////////////////
  // Cycles since the cause pins were high, strobe gap and zoom age
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      quiet_ev_q <= 8'hFF;
      quiet_zm_q <= 8'hFF;
      gap_q      <= 32'h0;
      zage_q     <= 32'h0;
    end else begin
      quiet_ev_q <= (infrared_motion_sensor | ir_blocked) ? 8'h00
                    : ((quiet_ev_q == 8'hFF) ? 8'hFF : quiet_ev_q + 8'h01);
      quiet_zm_q <= (prox_detect | touch_detect) ? 8'h00
                    : ((quiet_zm_q == 8'hFF) ? 8'hFF : quiet_zm_q + 8'h01);
      gap_q      <= sample_strobe ? 32'h0 : gap_q + 32'h1;
      zage_q     <= zoom_mode ? zage_q + 32'h1 : 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bus handshake and read data
  chk_wait_once: assert property ((read | write) && waitrequest |=> !waitrequest)
    else $error("access waited more than one cycle");
  chk_wait_idle: assert property (!(read | write) |-> !waitrequest)
    else $error("waitrequest high without a request");
  chk_wait_first: assert property ($rose(read | write) |-> waitrequest)
    else $error("no wait cycle at start of access");
  chk_read_unmapped: assert property (read && !waitrequest && address == 8'h18 |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!read |=> $stable(readdata))
    else $error("readdata changed without a read");

  ////////////////////////////////////////////////////////////////////////////////
  // Output pin, event and sampler
  chk_oe_drive: assert property (!out_oe |-> out_level)
    else $error("open drain released while low");
  chk_event_cause: assert property (event_out |-> quiet_ev_q < 8'h0A)
    else $error("event output without cause");
  chk_zoom_cause: assert property (zoom_mode |-> quiet_zm_q < 8'h0A)
    else $error("zoom mode without prox or touch");
  chk_zoom_rate: assert property (zoom_mode && zage_q > 2 * ZOOM_CYCLES |-> gap_q <= ZOOM_CYCLES)
    else $error("zoom strobe period too long");
endmodule // sensor_output_event_controller_properties

// ===== light_load.sv
// Lighting load on the main output pin, with pull-up for open drain
`timescale 1ns/1ps
module light_load (
  input  wire out_level,
  input  wire out_oe,
  input  wire active_low,
  output wire pin,
  output wire lamp_on
);
  // Released pin is pulled high
  assign pin     = out_oe ? out_level : 1'b1;
  // Lamp lit at the configured on level
  assign lamp_on = pin ^ active_low;
endmodule // light_load

// ===== testbench.sv
// Self-checking bench for the sensor output event controller
`timescale 1ns/1ps
`include "sensor_output_map.vh"
module testbench;
  localparam integer ZC = 20;
  reg         clock, rst, read, write, motion, blocked, prox, touch, metal, coil, act_low;
  reg         ws, ss;
  reg  [7:0]  address;
  reg  [31:0] writedata, rs, d;
  wire [31:0] readdata;
  wire        waitrequest, out_level, out_oe, event_out, sample_strobe, zoom_mode, pin, lamp_on;
  integer     n_fail, checked, cyc, g;

  sensor_output_event_controller #(.MS_CYCLES(10), .HOLD_CYCLES(50), .ZOOM_CYCLES(ZC),
    .DUTY_WIDTH(8)) dut (.clock(clock), .rst(rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .infrared_motion_sensor(motion), .ir_blocked(blocked), .prox_detect(prox),
    .touch_detect(touch), .metal_detect(metal), .coil_touch(coil), .out_level(out_level),
    .out_oe(out_oe), .event_out(event_out), .sample_strobe(sample_strobe),
    .zoom_mode(zoom_mode));
  light_load load (.out_level(out_level), .out_oe(out_oe), .active_low(act_low), .pin(pin),
    .lamp_on(lamp_on));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, settled samples before each rising edge, timeout
  initial clock = 1'b0;
  always #5 clock = ~clock;
  always @(negedge clock) begin
    ws = waitrequest;
    rs = readdata;
    ss = sample_strobe;
  end
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 12000) begin
      n_fail = n_fail + 1;
      end_of_test;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Tasks
  task end_of_test;
    begin
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] s);
    begin
      checked = checked + 1;
      if (s !== e) begin
        $display("wrong value %s expected %h seen %h", nm, e, s);
        n_fail = n_fail + 1;
      end
    end
  endtask
  task wt(input integer n);
    repeat (n) @(posedge clock);
  endtask
  // One Avalon access, held until waitrequest is seen low
  task bus(input w, input [7:0] a, input [31:0] v);
    begin
      address   <= a;
      writedata <= v;
      read      <= ~w;
      write     <= w;
      do @(posedge clock); while (ws);
      d = rs;
      read  <= 1'b0;
      write <= 1'b0;
      @(posedge clock);
    end
  endtask
  task sst(input [1:0] e);
    begin
      bus(1'b0, `REG_STATUS, 32'h0);
      chk("state", {30'h0, e}, {30'h0, d[1:0]});
    end
  endtask
  // Strobe period in cycles
  task gap;
    begin
      g = 0;
      do @(posedge clock); while (!ss);
      do begin
        @(posedge clock);
        g = g + 1;
      end while (!ss);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst, read, write, motion, blocked, prox, touch, metal, coil, act_low} = 10'h200;
    address = 8'h00;
    writedata = 32'h0;
    n_fail = 0;
    checked = 0;
    cyc = 0;
    wt(6);
    rst <= 1'b0;
    wt(1);
    bus(1'b0, `REG_CTRL, 32'h0); chk("ctrl", 32'h0, d);
    bus(1'b0, `REG_DEACT_MS, 32'h0); chk("deact", 32'h2710, d);
    bus(1'b0, `REG_RAMP_MS, 32'h0); chk("ramp", 32'hA, d);
    bus(1'b0, `REG_SAMPLE_MS, 32'h0); chk("sample", 32'h64, d);
    bus(1'b0, `REG_DUTY_DEFAULT, 32'h0); chk("duty def", 32'hFF, d);
    bus(1'b0, `REG_STATUS, 32'h0); chk("status", 32'hFF00, d & 32'hFF07);
    bus(1'b1, 8'h18, 32'hFFFF);
    bus(1'b0, 8'h18, 32'h0); chk("unmapped", 32'h0, d);
    bus(1'b1, `REG_DUTY_DEFAULT, 32'h80);
    bus(1'b0, `REG_DUTY_DEFAULT, 32'h0); chk("duty def wr", 32'h80, d);
    bus(1'b1, `REG_STATUS, 32'h3);
    sst(2'h0);
    bus(1'b1, `REG_DEACT_MS, 32'h4);
    bus(1'b1, `REG_RAMP_MS, 32'h1);
    bus(1'b1, `REG_SAMPLE_MS, 32'h5);
    gap; chk("normal rate", 32'h32, g);
    // Movement, timer restart, timeout
    motion <= 1'b1; wt(8); sst(2'h1);
    chk("event", 32'h1, {31'h0, event_out});
    motion <= 1'b0; wt(12); chk("event off", 32'h0, {31'h0, event_out});
    motion <= 1'b1; wt(8); motion <= 1'b0; wt(20); sst(2'h1);
    wt(30); sst(2'h0);
    // Touch in PWM mode, movement while active, touch off
    motion <= 1'b1; wt(8); motion <= 1'b0; sst(2'h1);
    touch <= 1'b1; wt(8); touch <= 1'b0; sst(2'h2);
    wt(8); motion <= 1'b1; wt(8); motion <= 1'b0; wt(8); sst(2'h2);
    touch <= 1'b1; wt(8); touch <= 1'b0; wt(8); sst(2'h0);
    // Prox and zoom sampling
    prox <= 1'b1; wt(8); sst(2'h0);
    chk("zoom", 32'h1, {31'h0, zoom_mode});
    gap; gap; chk("zoom rate", ZC, g);
    prox <= 1'b0; wt(12); chk("zoom off", 32'h0, {31'h0, zoom_mode});
    // Held touch: dim down, reverse at zero, hold on release
    touch <= 1'b1; wt(30);
    bus(1'b0, `REG_STATUS, 32'h0); chk("no dim yet", 32'hFF02, d & 32'hFF03);
    wt(70);
    bus(1'b0, `REG_STATUS, 32'h0); chk("dim start", 32'h1, {31'h0, d[15:8] < 8'hFF});
    wt(2700);
    bus(1'b0, `REG_STATUS, 32'h0);
    chk("dim up", 32'h1, {31'h0, d[3] && d[15:8] != 8'h0 && d[15:8] < 8'h20});
    touch <= 1'b0; wt(10);
    bus(1'b0, `REG_STATUS, 32'h0); g = d[15:8]; wt(40);
    bus(1'b0, `REG_STATUS, 32'h0); chk("held duty", g, {24'h0, d[15:8]});
    // Metal mode and coil touch suppression
    bus(1'b1, `REG_CTRL, 32'h4); wt(4); sst(2'h2);
    metal <= 1'b1; wt(8); sst(2'h0);
    bus(1'b1, `REG_CTRL, 32'hC); coil <= 1'b1; wt(8);
    metal <= 1'b0; wt(8); sst(2'h0);
    coil <= 1'b0; wt(8); sst(2'h2);
    // Output polarity and drive
    metal <= 1'b1; act_low <= 1'b1; bus(1'b1, `REG_CTRL, 32'hD); wt(8);
    chk("low pol", 32'h1, {31'h0, out_level});
    chk("lamp off", 32'h0, {31'h0, lamp_on});
    act_low <= 1'b0; bus(1'b1, `REG_CTRL, 32'h6); wt(4);
    chk("od drive", 32'h1, {31'h0, out_oe});
    chk("od pin", 32'h0, {31'h0, pin});
    metal <= 1'b0; wt(8); g = 0;
    repeat (512) begin
      @(posedge clock);
      if (lamp_on === 1'b1) g = g + 1;
    end
    chk("pwm", 32'h1, {31'h0, g > 0 && g < 512});
    blocked <= 1'b1; wt(8); chk("blocked", 32'h1, {31'h0, event_out});
    blocked <= 1'b0;
    end_of_test;
  end
endmodule // testbench

bind sensor_output_event_controller sensor_output_event_controller_properties
  #(.ZOOM_CYCLES(ZOOM_CYCLES)) props (.clock(clock), .rst(rst), .address(address),
  .read(read), .write(write), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .infrared_motion_sensor(infrared_motion_sensor),
  .ir_blocked(ir_blocked), .prox_detect(prox_detect), .touch_detect(touch_detect),
  .metal_detect(metal_detect), .coil_touch(coil_touch), .out_level(out_level),
  .out_oe(out_oe), .event_out(event_out), .sample_strobe(sample_strobe),
  .zoom_mode(zoom_mode));
